// ### core/adc_cfg_pkg.sv
package adc_cfg_pkg;

    // Frame geometry on the serial link.
    localparam int unsigned FRAME_BITS  = 16;
    localparam logic [4:0]  LAST_FALL   = 5'h0F;
    localparam logic [4:0]  FALL_SAT    = 5'h10;
    localparam logic [3:0]  TRACK_RISE  = 4'hE;

    // Positions inside a received frame, MSB first.
    localparam int unsigned WR_POS      = 15;
    localparam int unsigned SEL_HI_POS  = 14;
    localparam int unsigned SEL_LO_POS  = 13;
    localparam int unsigned CTRL_HI_POS = 12;
    localparam int unsigned CTRL_LO_POS = 1;
    localparam int unsigned BYTE_HI_POS = 12;
    localparam int unsigned BYTE_LO_POS = 5;

    // Register select codes.
    localparam logic [1:0]  SEL_CTRL    = 2'h0;
    localparam logic [1:0]  SEL_RANGE1  = 2'h1;
    localparam logic [1:0]  SEL_RANGE2  = 2'h2;
    localparam logic [1:0]  SEL_SEQ     = 2'h3;

    // Fields of conversion_control, as stored.
    localparam int unsigned CC_CHAN_HI  = 11;
    localparam int unsigned CC_CHAN_LO  = 9;
    localparam int unsigned CC_CFG_HI   = 8;
    localparam int unsigned CC_CFG_LO   = 7;
    localparam int unsigned CC_PWR_HI   = 6;
    localparam int unsigned CC_PWR_LO   = 5;
    localparam int unsigned CC_CODING   = 4;
    localparam int unsigned CC_REF      = 3;
    localparam int unsigned CC_SCAN_HI  = 2;
    localparam int unsigned CC_SCAN_LO  = 1;
    localparam int unsigned CC_IDLE     = 0;

    // Values after reset and mode codes.
    localparam logic [11:0] CTRL_RST    = 12'h000;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    localparam logic [1:0]  CFG_SINGLE  = 2'h0;
    localparam logic [1:0]  SCAN_CONSEC = 2'h3;
    localparam logic [2:0]  CHAN_FIRST  = 3'h0;

endpackage : adc_cfg_pkg

// ### core/link_if.sv
`timescale 1ns/10ps

interface link_if;
    logic [15:0] frame_word;
    logic        frame_tog;
    logic        track;
    logic [15:0] tx_word;
    logic        next_msb;

    modport link (
        output frame_word,
        output frame_tog,
        output track,
        input  tx_word,
        input  next_msb
    );

    modport core (
        input  frame_word,
        input  frame_tog,
        input  track,
        output tx_word,
        output next_msb
    );
endinterface : link_if

// ### core/bit_sync.sv
`timescale 1ns/10ps

module bit_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // bit_sync

// ### core/serial_link.sv
`timescale 1ns/10ps

module serial_link
    import adc_cfg_pkg::*;
(
    input  wire logic sclk,
    input  wire logic rst,
    input  wire logic cs_n,
    input  wire logic din,
    output logic      dout,
    link_if.link      lk
);
    logic [4:0]  fall_cnt_r;
    logic [3:0]  rise_cnt_r;
    logic [14:0] shift_r;
    logic        trk_tog_r;
    logic        hold_tog_r;
    logic        link_clr;

    // A raised chip select aborts any partial frame without needing sclk.
    assign link_clr = rst | cs_n;

    always_ff @(negedge sclk or posedge link_clr) begin
        if (link_clr) begin
            fall_cnt_r <= 5'h00;
            shift_r    <= 15'h0000;
        end else if (fall_cnt_r != FALL_SAT) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
            shift_r    <= {shift_r[13:0], din};
        end
    end

    // Only a frame reaching its sixteenth falling edge is handed over.
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            lk.frame_word <= 16'h0000;
            lk.frame_tog  <= 1'b0;
        end else if (!cs_n && fall_cnt_r == LAST_FALL) begin
            lk.frame_word <= {shift_r, din};
            lk.frame_tog  <= ~lk.frame_tog;
        end
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            dout <= 1'b0;
        end else if (!cs_n && fall_cnt_r == LAST_FALL) begin
            dout <= lk.next_msb;
        end else if (!cs_n && fall_cnt_r < LAST_FALL) begin
            dout <= lk.tx_word[4'hE - fall_cnt_r[3:0]];
        end
    end

    // The conversion is paced by sclk until the tracking edge.
    always_ff @(posedge sclk or posedge link_clr) begin
        if (link_clr) begin
            rise_cnt_r <= 4'h0;
        end else if (rise_cnt_r != TRACK_RISE) begin
            rise_cnt_r <= rise_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            trk_tog_r <= 1'b0;
        end else if (!cs_n && rise_cnt_r == TRACK_RISE - 4'h1) begin
            trk_tog_r <= ~trk_tog_r;
        end
    end

    // Hold is entered on the chip select edge itself, not on a clock.
    always_ff @(negedge cs_n or posedge rst) begin
        if (rst) begin
            hold_tog_r <= 1'b0;
        end else begin
            hold_tog_r <= trk_tog_r;
        end
    end

    assign lk.track = trk_tog_r ^ hold_tog_r;
endmodule // serial_link

// ### core/adc_serial_ctrl.sv
`timescale 1ns/10ps

// Summary of operation
// - After reset inputs are eight single-ended channels until control changes them.
// - Track begins on the fourteenth sclk rising edge after chip select falls.
// - Hold resumes, freezing the input, when chip select falls again.
// - A frame is exactly sixteen sclk cycles with chip select low.
// - The first three frame bits are write flag and two select bits.
// - A clear write flag leaves every register unchanged.
// - Write with select 00 loads twelve bits into the control register.
// - Select 01, 10, 11 load eight bits into range one, two, sequence.
// - All four registers are write only; nothing reads them back.
// - A control write takes effect at the next conversion, not the current.
// - The control register powers up cleared to zero.
// - Control frame bit order: flag, selects, channel, config, power, coding, ref, scan, idle, 0.
// - The serial clock both shifts data and paces the conversion.
// - Channel bits pick the next input, or the last channel of a scan.
// - Coding 0 gives two's complement, 1 straight binary, from the configuration frozen at conversion start.
// - Idle bit 1 weakly drives the next channel MSB; 0 releases the output.
module adc_serial_ctrl
    import adc_cfg_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    input  wire logic [12:0] adc_result,
    output logic             dout,
    output logic             dout_oe_n,
    output logic             dout_weak,
    output logic             track_en,
    output logic             conv_busy,
    output logic             frame_abort,
    output logic [2:0]       channel_pointer_bits,
    output logic [1:0]       input_config_bits,
    output logic [1:0]       power_state_bits,
    output logic             coding_sel,
    output logic             int_ref_en,
    output logic [7:0]       range_one,
    output logic [7:0]       range_two,
    output logic [7:0]       scan_order
);

    // Tracks the conversion that the current frame paces.
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_FINISH
    } conv_state_e;

    link_if lk ();

    conv_state_e conv_state_r;
    conv_state_e conv_state_nxt;

    logic        cs_act_s;
    logic        cs_n_s;
    logic        cs_n_d_r;
    logic        tog_s;
    logic        tog_d_r;
    logic        track_s;
    logic        cs_fall;
    logic        cs_rise;
    logic        frame_new;

    logic [15:0] word_r;
    logic        word_ok_r;
    logic        wr_flag;
    logic [1:0]  sel;

    logic [11:0] conversion_control_r;
    logic [7:0]  range1_r;
    logic [7:0]  range2_r;
    logic [7:0]  seq_r;
    logic        ctrl_wr_r;

    logic [11:0] act_ctrl_r;
    logic [2:0]  next_chan_r;
    logic [2:0]  conv_chan_r;
    logic        scan_on;

    logic [12:0] coded;
    logic [15:0] tx_word_r;

    // Control pins and the frame toggle come from the link side.
    // Chip select is carried inverted, so the synchroniser's reset value means
    // deselected and the output enable cannot drop for two cycles after reset.
    bit_sync u_cs_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   (~cs_n),
        .q   (cs_act_s)
    );

    assign cs_n_s = ~cs_act_s;

    bit_sync u_tog_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   (lk.frame_tog),
        .q   (tog_s)
    );

    // Tracking passes the same two stages, so track_en lags the analog switch.
    bit_sync u_trk_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   (lk.track),
        .q   (track_s)
    );

    // The link runs on sclk and chip select; only toggles, the track level and a settled word cross over.
    serial_link u_link (
        .sclk (sclk),
        .rst  (rst),
        .cs_n (cs_n),
        .din  (din),
        .dout (dout),
        .lk   (lk.link)
    );

    // Each delayed copy resets to the idle level of its source, so no false edge follows reset.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cs_n_d_r <= 1'b1;
            tog_d_r  <= 1'b0;
        end else begin
            cs_n_d_r <= cs_n_s;
            tog_d_r  <= tog_s;
        end
    end

    // A frame is announced by a change of the toggle, which a slow domain cannot miss.
    assign cs_fall   = cs_n_d_r & ~cs_n_s;
    assign cs_rise   = ~cs_n_d_r & cs_n_s;
    assign frame_new = tog_s ^ tog_d_r;

    // The frame word is held by the link until the next complete frame,
    // many sclk periods later, so it is stable once the toggle is seen.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_r    <= 16'h0000;
            word_ok_r <= 1'b0;
        end else begin
            word_ok_r <= frame_new;
            if (frame_new) begin
                word_r <= lk.frame_word;
            end
        end
    end

    // A frame with a clear write flag is decoded as usual and matches no write below.
    assign wr_flag = word_r[WR_POS];
    assign sel     = {word_r[SEL_HI_POS], word_r[SEL_LO_POS]};

    // No read path exists for any of these registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conversion_control_r <= CTRL_RST;
        end else if (word_ok_r && wr_flag && sel == SEL_CTRL) begin
            conversion_control_r <= word_r[CTRL_HI_POS:CTRL_LO_POS];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            range1_r <= BYTE_RST;
            range2_r <= BYTE_RST;
            seq_r    <= BYTE_RST;
        end else if (word_ok_r && wr_flag) begin
            if (sel == SEL_RANGE1) begin
                range1_r <= word_r[BYTE_HI_POS:BYTE_LO_POS];
            end else if (sel == SEL_RANGE2) begin
                range2_r <= word_r[BYTE_HI_POS:BYTE_LO_POS];
            end else if (sel == SEL_SEQ) begin
                seq_r <= word_r[BYTE_HI_POS:BYTE_LO_POS];
            end
        end
    end

    // Marks that a control write is waiting to restart the scan.
    // A write in the same cycle as a chip select fall wins, so it is never lost.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_wr_r <= 1'b0;
        end else if (word_ok_r && wr_flag && sel == SEL_CTRL) begin
            ctrl_wr_r <= 1'b1;
        end else if (cs_fall) begin
            ctrl_wr_r <= 1'b0;
        end
    end

    // Conversion tracker: a conversion starts at chip select fall and its
    // result is ready when the frame that paced it completes.
    // An aborted frame leaves no result, so the previous word is shifted again.
    always_comb begin
        conv_state_nxt = conv_state_r;
        case (conv_state_r)
            CONV_IDLE: begin
                if (cs_fall) begin
                    conv_state_nxt = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (word_ok_r) begin
                    conv_state_nxt = CONV_FINISH;
                end else if (cs_rise && !frame_new) begin
                    conv_state_nxt = CONV_IDLE;
                end
            end
            CONV_FINISH: begin
                conv_state_nxt = CONV_IDLE;
            end
            default: begin
                conv_state_nxt = CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conv_state_r <= CONV_IDLE;
        end else begin
            conv_state_r <= conv_state_nxt;
        end
    end

    // Configuration is frozen at the start of a conversion, so a control
    // word arriving during that frame only reaches the following one.
    // After reset the frozen configuration selects eight single-ended inputs.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            act_ctrl_r  <= CTRL_RST;
            conv_chan_r <= CHAN_FIRST;
        end else if (cs_fall) begin
            act_ctrl_r  <= conversion_control_r;
            conv_chan_r <= next_chan_r;
        end
    end

    // Only the consecutive code runs a scan; other codes keep a fixed channel.
    assign scan_on = conversion_control_r[CC_SCAN_HI:CC_SCAN_LO] == SCAN_CONSEC;

    // Scans run from the first channel up to the channel bits, then wrap.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            next_chan_r <= CHAN_FIRST;
        end else if (!scan_on) begin
            next_chan_r <= conversion_control_r[CC_CHAN_HI:CC_CHAN_LO];
        end else if (ctrl_wr_r && cs_fall) begin
            next_chan_r <= CHAN_FIRST + 3'h1;
        end else if (ctrl_wr_r) begin
            next_chan_r <= CHAN_FIRST;
        end else if (cs_fall) begin
            if (next_chan_r == conversion_control_r[CC_CHAN_HI:CC_CHAN_LO]) begin
                next_chan_r <= CHAN_FIRST;
            end else begin
                next_chan_r <= next_chan_r + 3'h1;
            end
        end
    end

    // Straight binary is the two's complement code with its sign flipped.
    assign coded = act_ctrl_r[CC_CODING] ?
                   {~adc_result[12], adc_result[11:0]} :
                   adc_result;

    // The result is captured once per completed frame and shifted out during
    // the next one, so every completed conversion is reported one frame late.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_word_r <= 16'h0000;
        end else if (conv_state_r == CONV_RUN && word_ok_r) begin
            tx_word_r <= {conv_chan_r, coded};
        end
    end

    // The link reads these only on sclk falling edges inside a frame, long after they settle.
    assign lk.tx_word  = tx_word_r;
    assign lk.next_msb = next_chan_r[2];

    // The enable follows the synchronised chip select, about three core cycles
    // behind the pin; a host must not sample the first bit before that.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dout_oe_n <= 1'b1;
            dout_weak <= 1'b0;
        end else if (!cs_n_s) begin
            dout_oe_n <= 1'b0;
            dout_weak <= 1'b0;
        end else begin
            dout_oe_n <= ~act_ctrl_r[CC_IDLE];
            dout_weak <= act_ctrl_r[CC_IDLE];
        end
    end

    // No abort is flagged when the toggle and the chip select rise meet,
    // since that frame did reach its sixteenth edge.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            track_en    <= 1'b0;
            conv_busy   <= 1'b0;
            frame_abort <= 1'b0;
        end else begin
            track_en    <= track_s;
            conv_busy   <= conv_state_nxt == CONV_RUN;
            frame_abort <= conv_state_r == CONV_RUN && cs_rise && !frame_new
                           && !word_ok_r;
        end
    end

    // Analog side settings follow the configuration of the running conversion.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            channel_pointer_bits <= CHAN_FIRST;
            input_config_bits    <= CFG_SINGLE;
            power_state_bits     <= 2'h0;
            coding_sel           <= 1'b0;
            int_ref_en           <= 1'b0;
        end else begin
            channel_pointer_bits <= conv_chan_r;
            input_config_bits    <= act_ctrl_r[CC_CFG_HI:CC_CFG_LO];
            power_state_bits     <= act_ctrl_r[CC_PWR_HI:CC_PWR_LO];
            coding_sel           <= act_ctrl_r[CC_CODING];
            int_ref_en           <= act_ctrl_r[CC_REF];
        end
    end

    // Range and sequence contents go straight to the analog front end.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            range_one  <= BYTE_RST;
            range_two  <= BYTE_RST;
            scan_order <= BYTE_RST;
        end else begin
            range_one  <= range1_r;
            range_two  <= range2_r;
            scan_order <= seq_r;
        end
    end

endmodule // adc_serial_ctrl

// ### sim/adc_serial_ctrl_assertions.sv
`timescale 1ns/10ps

module adc_serial_ctrl_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        din,
    input wire logic [12:0] adc_result,
    input wire logic        dout,
    input wire logic        dout_oe_n,
    input wire logic        dout_weak,
    input wire logic        track_en,
    input wire logic        conv_busy,
    input wire logic        frame_abort,
    input wire logic [2:0]  channel_pointer_bits,
    input wire logic [1:0]  input_config_bits,
    input wire logic [1:0]  power_state_bits,
    input wire logic        coding_sel,
    input wire logic        int_ref_en,
    input wire logic [7:0]  range_one,
    input wire logic [7:0]  range_two,
    input wire logic [7:0]  scan_order
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    hold_on_select_a: assert property ($fell(cs_n) |-> ##5 !track_en [*4])
        else $error("track stayed on after chip select fell");
    track_edge_a: assert property ($rose(track_en) |-> !$past(cs_n, 3))
        else $error("tracking began outside a frame");
    busy_start_a: assert property ($fell(cs_n) |-> ##[1:5] conv_busy)
        else $error("conversion did not start with the frame");
    abort_pulse_a: assert property (frame_abort |=> !frame_abort)
        else $error("abort pulse longer than one cycle");
    abort_idle_a: assert property (frame_abort |-> cs_n)
        else $error("abort flagged while chip select low");
    config_latch_a: assert property (!$stable({channel_pointer_bits, input_config_bits,
        power_state_bits, coding_sel, int_ref_en}) |-> !cs_n)
        else $error("control fields changed outside a conversion start");
    range_update_a: assert property (!$stable({range_one, range_two, scan_order})
        |-> cs_n && !$past(cs_n, 8))
        else $error("range or sequence byte changed inside a frame");
    idle_drive_a: assert property (cs_n && $past(cs_n, 4) && !dout_oe_n |-> dout_weak)
        else $error("output driven strongly while idle");

    cover property ($rose(frame_abort));
    cover property ($rose(track_en));
    cover property ($rose(dout_weak));
endmodule // adc_serial_ctrl_checker

bind adc_serial_ctrl adc_serial_ctrl_checker chk (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .adc_result(adc_result), .dout(dout), .dout_oe_n(dout_oe_n),
    .dout_weak(dout_weak), .track_en(track_en), .conv_busy(conv_busy),
    .frame_abort(frame_abort), .channel_pointer_bits(channel_pointer_bits),
    .input_config_bits(input_config_bits), .power_state_bits(power_state_bits),
    .coding_sel(coding_sel), .int_ref_en(int_ref_en), .range_one(range_one),
    .range_two(range_two), .scan_order(scan_order)
);

// ### sim/host_model.sv
`timescale 1ns/10ps

module host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    logic [15:0] rx;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
        rx   = 16'h0000;
    end

    // The clock only runs inside a frame; a short count models a host that quits early.
    task automatic send(input logic [15:0] w, input int n);
        // Starting 1.5 ns after the call keeps link edges off the core clock edges unless the call itself starts 0.5 ns past that grid.
        #1.5;
        cs_n = 1'b0;
        din  = w[15];
        #6;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            #6;
            if (i < 15) rx[14-i] = dout;
            sclk = 1'b1;
            if (i < 15) din = w[14-i];
            #6;
        end
        cs_n = 1'b1;
        din  = ~din;
        #120;
    endtask
endmodule // host_model

// ### sim/test_adc_serial_ctrl.sv
`timescale 1ns/10ps

module test_adc_serial_ctrl;
    import adc_cfg_pkg::*;

    logic        ref_clk;
    logic        rst;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic [12:0] adc_result;
    logic        dout;
    logic        dout_oe_n;
    logic        dout_weak;
    logic        track_en;
    logic        conv_busy;
    logic        frame_abort;
    logic [2:0]  chan;
    logic [1:0]  cfg;
    logic [1:0]  pwr;
    logic        coding;
    logic        refsel;
    logic [7:0]  r1;
    logic [7:0]  r2;
    logic [7:0]  seq;
    logic        abort_seen;
    int          n_errors;
    int          n_tests;

    adc_serial_ctrl uut (
        .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .adc_result(adc_result), .dout(dout), .dout_oe_n(dout_oe_n),
        .dout_weak(dout_weak), .track_en(track_en), .conv_busy(conv_busy),
        .frame_abort(frame_abort), .channel_pointer_bits(chan),
        .input_config_bits(cfg), .power_state_bits(pwr), .coding_sel(coding),
        .int_ref_en(refsel), .range_one(r1), .range_two(r2), .scan_order(seq)
    );

    // A released output reads as the inverse, so a late enable corrupts the bits.
    host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_oe_n ? ~dout : dout));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (frame_abort === 1'b1) abort_seen = 1'b1;
    end

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic test_reset();
        compare(32'({dout_oe_n, dout_weak, track_en, conv_busy, frame_abort}), 32'h10);
        compare(32'(cfg), 32'(CFG_SINGLE));
        compare(32'({chan, cfg, pwr, coding, refsel}), 32'h0);
        compare(32'({r1, r2, seq}), 32'h0);
    endtask

    // Ranges and sequence go in before any control write, as a host must.
    task automatic test_ranges();
        logic [7:0] bytes [3];
        bytes = '{8'hA5, 8'h5A, 8'hC3};
        for (int s = 1; s < 4; s++) begin
            host.send({1'b1, 2'(s), bytes[s-1], 5'h00}, 16);
        end
        compare(32'({r1, r2, seq}), 32'hA55AC3);
        compare(32'(track_en), 32'h1);
    endtask

    task automatic test_no_write();
        host.send({1'b0, SEL_RANGE1, 8'hFF, 5'h00}, 16);
        compare(32'({r1, r2, seq}), 32'hA55AC3);
    endtask

    task automatic test_abort();
        abort_seen = 1'b0;
        host.send({1'b1, SEL_RANGE1, 8'h11, 5'h00}, 8);
        compare(32'(abort_seen), 32'h1);
        compare(32'(r1), 32'hA5);
        compare(32'(track_en), 32'h0);
    endtask

    task automatic test_control();
        logic [11:0] ctrl;
        ctrl = {3'h5, 2'h2, 2'h1, 1'b1, 1'b1, 2'h0, 1'b1};
        host.send({1'b1, SEL_CTRL, ctrl, 1'b0}, 16);
        compare(32'({chan, cfg, pwr, coding, refsel}), 32'h0);
        compare(32'({dout_oe_n, dout_weak}), 32'h2);
        host.send({1'b0, SEL_SEQ, 12'hFFF, 1'b0}, 16);
        compare(32'({chan, cfg, pwr, coding, refsel}), 32'h167);
        compare(32'({r1, r2, seq}), 32'hA55AC3);
        compare(32'(dout_weak), 32'h1);
        compare(32'(dout), 32'h1);
        compare(32'(host.rx[11:0]), 32'(adc_result[11:0]));
    endtask

    // Follows test_control: the first word out is channel 5 in straight binary.
    // A scan ending at channel 2 then visits 0, 1, 2 and wraps to 0.
    task automatic test_scan();
        logic [2:0]  order [4];
        logic [15:0] sb;
        order = '{3'h0, 3'h1, 3'h2, 3'h0};
        sb    = {3'h5, ~adc_result[12], adc_result[11:0]};
        host.send({1'b1, SEL_CTRL, 3'h2, 6'h00, SCAN_CONSEC, 1'b0, 1'b0}, 16);
        compare(32'(host.rx[14:0]), 32'(sb[14:0]));
        for (int k = 0; k < 4; k++) begin
            host.send({1'b0, SEL_CTRL, 12'h000, 1'b0}, 16);
            compare(32'(chan), 32'(order[k]));
        end
    endtask

    initial begin
        n_errors   = 0;
        n_tests    = 0;
        abort_seen = 1'b0;
        rst        = 1'b1;
        adc_result = 13'h1A5C;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        repeat (6) @(negedge ref_clk);
        test_reset();
        test_ranges();
        test_no_write();
        test_abort();
        test_control();
        test_scan();
        report_and_stop();
    end

    // A hang is cut short and counted as a mismatch.
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule // test_adc_serial_ctrl
